// ### rtl/adc_output_formatter.v
// Output stage: sample coding, output clock generation, output drivers, power-down
//
// Notes on behaviour
// - Internal termination on raises LVDS driver current 1.6 times the chosen setting.
// - Overflow flag high beyond range, same latency as its sample bits.
// - Full-rate CMOS: data changes with falling edge of positive output clock.
// - DDR modes: data changes on both falling and rising clock edges.
// - Output clock delayed 0, 45, 90 or 135 degrees of sample period.
// - Clock inversion independent of shift, giving 0 to 315 degrees.
// - Offset binary after reset; two's complement when format bit set.
// - Midscale is 1000 0000 0000; two's complement inverts top bit.
// - Randomizer XORs every bit above LSB with the LSB.
// - Randomizer leaves LSB, overflow flag and output clock untouched.
// - Randomizer and alternate polarity enable independently, both allowed.
// - Alternate polarity forces offset binary, ignoring two's complement.
// - Test patterns: all ones, all zeros, alternating, checkerboard.
// - Active test pattern overrides every other formatting option.
// - Output disable floats data, overflow and output clock.
// - Sleep powers everything down; about 2 ms before samples trusted.
// - Nap keeps references; 100 cycles plus 50 us before trusting.
// - Phase field 00..11 means 0, 1/8, 1/4, 3/8 sample period.
// - Power-down field: 00 normal, 01 nap, 11 sleep, 10 unused.
// - DDR: two adjacent bits per line on six lines, one per edge.
`timescale 1ns/1ps
`default_nettype none
`include "adc_output_formatter_regs.vh"

module adc_output_formatter #(
  parameter integer SAMPLE_W = `SAMPLE_W,
  parameter integer NAP_WAKE_CYCLES = `NAP_MIN_SAMPLES * `TICKS_PER_SAMPLE
    + (`NAP_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter integer SLEEP_WAKE_CYCLES = (`SLEEP_SETTLE_NS + `CLK_PERIOD_NS - 1)
    / `CLK_PERIOD_NS
) (
  input wire clk,
  input wire rst_b,
  input wire [SAMPLE_W-1:0] raw_sample,
  input wire raw_over_range,
  input wire twos_complement_en,
  input wire randomizer_en,
  input wire alt_polarity_en,
  input wire [2:0] test_pattern_sel,
  input wire [1:0] output_mode,
  input wire output_disable,
  input wire termination_en,
  input wire [2:0] lvds_current_sel,
  input wire [1:0] clock_phase_field,
  input wire clock_invert,
  input wire [1:0] power_down_field,
  output reg [SAMPLE_W-1:0] sample_bits,
  output reg [SAMPLE_W-1:0] sample_bits_oe,
  output reg over_range_flag,
  output reg over_range_flag_oe,
  output reg forwarded_clock_pos,
  output reg forwarded_clock_neg,
  output reg forwarded_clock_oe,
  output reg [2:0] lvds_current_code,
  output reg lvds_current_boost,
  output reg lvds_termination_on,
  output reg core_power_down,
  output reg reference_power_down,
  output reg samples_settling
);

  reg [`PHASE_W-1:0] phase_reg;
  reg [`PHASE_W-1:0] phase_next;
  reg pattern_toggle_reg;
  reg [SAMPLE_W-1:0] held_sample_reg;
  reg held_over_range_reg;
  reg [`SETTLE_W-1:0] settle_count_reg;
  reg [`SETTLE_W-1:0] settle_count_next;
  reg [1:0] prev_power_reg;
  reg [SAMPLE_W-1:0] bits_next;
  reg [SAMPLE_W-1:0] oe_next;
  reg clock_next;
  reg is_ddr;
  wire [SAMPLE_W-1:0] coded_sample;
  wire coded_over_range;

  // Is the mode double data rate
  function ddr_mode;
    input [1:0] mode;
    begin
      ddr_mode = (mode == `MODE_DDR_LVDS) || (mode == `MODE_DDR_CMOS);
    end
  endfunction

  // Output clock level at a tick, delayed by the phase field in eighths
  function clock_level;
    input [`PHASE_W-1:0] tick;
    input [1:0] shift;
    input invert;
    reg [`PHASE_W-1:0] delayed;
    begin
      delayed = tick - {1'b0, shift};
      clock_level = delayed[`HALF_BIT] ^ invert;
    end
  endfunction

  sample_formatter u_fmt (
    .raw_sample(raw_sample),
    .raw_over_range(raw_over_range),
    .twos_complement_en(twos_complement_en),
    .randomizer_en(randomizer_en),
    .alt_polarity_en(alt_polarity_en),
    .test_pattern_sel(test_pattern_sel),
    .pattern_toggle(pattern_toggle_reg),
    .coded_sample(coded_sample),
    .coded_over_range(coded_over_range)
  );

  // Sample period tick counter and next output values
  integer i;
  always @* begin
    phase_next = phase_reg + 3'h1;
    is_ddr = ddr_mode(output_mode);
    bits_next = `ZERO_DATA;
    oe_next = `ZERO_DATA;
    if (is_ddr) begin
      // First half carries even bits, second half odd bits
      for (i = 0; i < SAMPLE_W / 2; i = i + 1) begin
        bits_next[i] = phase_reg[`HALF_BIT] ? held_sample_reg[2 * i + 1]
          : held_sample_reg[2 * i];
        oe_next[i] = !output_disable;
      end
    end else begin
      bits_next = held_sample_reg;
      oe_next = {SAMPLE_W{!output_disable}};
    end
    clock_next = clock_level(phase_reg, clock_phase_field, clock_invert);
  end

  // Settling timer after leaving nap or sleep
  always @* begin
    settle_count_next = settle_count_reg;
    if (power_down_field != `PD_NORMAL) begin
      settle_count_next = {`SETTLE_W{1'b0}};
    end else if (prev_power_reg == `PD_SLEEP) begin
      settle_count_next = SLEEP_WAKE_CYCLES[`SETTLE_W-1:0];
    end else if (prev_power_reg == `PD_NAP) begin
      settle_count_next = NAP_WAKE_CYCLES[`SETTLE_W-1:0];
    end else if (settle_count_reg != {`SETTLE_W{1'b0}}) begin
      settle_count_next = settle_count_reg - {{(`SETTLE_W-1){1'b0}}, 1'b1};
    end
  end

  // Tick within the sample period
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_reg <= `PHASE_LAST;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // Power field of the last cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_power_reg <= `PD_NORMAL;
    end else begin
      prev_power_reg <= power_down_field;
    end
  end

  // Settling counter
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      settle_count_reg <= {`SETTLE_W{1'b0}};
    end else begin
      settle_count_reg <= settle_count_next;
    end
  end

  // One new coded sample per period, flag travels with it
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pattern_toggle_reg <= 1'b0;
      held_sample_reg <= `ZERO_DATA;
      held_over_range_reg <= 1'b0;
    end else if (phase_reg == `PHASE_LAST && power_down_field == `PD_NORMAL) begin
      held_sample_reg <= coded_sample;
      held_over_range_reg <= coded_over_range;
      pattern_toggle_reg <= !pattern_toggle_reg;
    end
  end

  // Registered pins
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sample_bits <= `ZERO_DATA;
    end else begin
      sample_bits <= bits_next;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sample_bits_oe <= `ZERO_DATA;
    end else begin
      sample_bits_oe <= oe_next;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      over_range_flag <= 1'b0;
    end else begin
      over_range_flag <= held_over_range_reg;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      over_range_flag_oe <= 1'b0;
    end else begin
      over_range_flag_oe <= !output_disable;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      forwarded_clock_pos <= 1'b0;
    end else begin
      forwarded_clock_pos <= clock_next;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      forwarded_clock_neg <= 1'b1;
    end else begin
      forwarded_clock_neg <= !clock_next;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      forwarded_clock_oe <= 1'b0;
    end else begin
      forwarded_clock_oe <= !output_disable;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lvds_current_code <= `LVDS_CUR_DEFAULT;
    end else begin
      lvds_current_code <= lvds_current_sel;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lvds_termination_on <= 1'b0;
    end else begin
      lvds_termination_on <= termination_en && (output_mode == `MODE_DDR_LVDS);
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lvds_current_boost <= 1'b0;
    end else begin
      lvds_current_boost <= termination_en && (output_mode == `MODE_DDR_LVDS);
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_power_down <= 1'b0;
    end else begin
      core_power_down <= (power_down_field == `PD_NAP)
        || (power_down_field == `PD_SLEEP);
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reference_power_down <= 1'b0;
    end else begin
      reference_power_down <= (power_down_field == `PD_SLEEP);
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      samples_settling <= 1'b0;
    end else begin
      samples_settling <= (power_down_field != `PD_NORMAL)
        || (settle_count_next != {`SETTLE_W{1'b0}});
    end
  end

endmodule // adc_output_formatter

`default_nettype wire

// ### rtl/adc_output_formatter_regs.vh
// Constants for the converter output formatter
`ifndef ADC_OUTPUT_FORMATTER_REGS_VH
`define ADC_OUTPUT_FORMATTER_REGS_VH

// Widths
`define SAMPLE_W 12
`define PAIR_W 6
`define PHASE_W 3

// Output mode field
`define MODE_FULL_CMOS 2'h0
`define MODE_DDR_LVDS 2'h1
`define MODE_DDR_CMOS 2'h2

// Power-down field
`define PD_NORMAL 2'h0
`define PD_NAP 2'h1
`define PD_SLEEP 2'h3

// Test pattern select
`define TP_OFF 3'h0
`define TP_ONES 3'h1
`define TP_ZEROS 3'h2
`define TP_ALTERNATE 3'h3
`define TP_CHECKER 3'h4

// Data codes
`define ODD_BIT_MASK 12'hAAA
`define EVEN_BIT_MASK 12'h555
`define ALL_ONES 12'hFFF
`define ALL_ZEROS 12'h000
`define SIGN_BIT 11

// Output clock timing: eight ticks per sample period
`define PHASE_LAST 3'h7
`define PHASE_FIRST 3'h0
`define HALF_BIT 2
`define SHIFT_NONE 2'h0

// Reset values
`define ZERO_DATA 12'h000
`define LVDS_CUR_DEFAULT 3'h0

// Power-up timing
`define CLK_PERIOD_NS 8
`define TICKS_PER_SAMPLE 8
`define NAP_MIN_SAMPLES 100
`define NAP_SETTLE_NS 50000
`define SLEEP_SETTLE_NS 2000000
`define SETTLE_W 18

`endif

// ### rtl/sample_formatter.v
// Combinational coding chain for one sample and its overflow flag
`timescale 1ns/1ps
`default_nettype none
`include "adc_output_formatter_regs.vh"

module sample_formatter (
  input wire [`SAMPLE_W-1:0] raw_sample,
  input wire raw_over_range,
  input wire twos_complement_en,
  input wire randomizer_en,
  input wire alt_polarity_en,
  input wire [2:0] test_pattern_sel,
  input wire pattern_toggle,
  output reg [`SAMPLE_W-1:0] coded_sample,
  output reg coded_over_range
);

  reg [`SAMPLE_W-1:0] coded;
  reg [`SAMPLE_W-1:0] scrambled;
  reg [`SAMPLE_W-1:0] polar;

  always @* begin
    // Format selection; polarity mode forces offset binary
    if (twos_complement_en && !alt_polarity_en) begin
      coded = raw_sample ^ (`ZERO_DATA | (12'h001 << `SIGN_BIT));
    end else begin
      coded = raw_sample;
    end
    // Randomizer: upper bits XOR with LSB, LSB untouched
    if (randomizer_en) begin
      scrambled = coded ^ ({`SAMPLE_W{coded[0]}} & ~`EVEN_BIT_MASK & ~12'h001)
        ^ ({`SAMPLE_W{coded[0]}} & `EVEN_BIT_MASK & ~12'h001);
    end else begin
      scrambled = coded;
    end
    // Odd bits inverted after randomizing
    if (alt_polarity_en) begin
      polar = scrambled ^ `ODD_BIT_MASK;
    end else begin
      polar = scrambled;
    end
    // Test pattern substituted last, overriding everything
    case (test_pattern_sel)
      `TP_ONES: begin
        coded_sample = `ALL_ONES;
        coded_over_range = 1'b1;
      end
      `TP_ZEROS: begin
        coded_sample = `ALL_ZEROS;
        coded_over_range = 1'b0;
      end
      `TP_ALTERNATE: begin
        coded_sample = pattern_toggle ? `ALL_ZEROS : `ALL_ONES;
        coded_over_range = !pattern_toggle;
      end
      `TP_CHECKER: begin
        coded_sample = pattern_toggle ? `ODD_BIT_MASK : `EVEN_BIT_MASK;
        coded_over_range = !pattern_toggle;
      end
      default: begin
        coded_sample = polar;
        coded_over_range = raw_over_range;
      end
    endcase
  end

endmodule // sample_formatter

`default_nettype wire

// ### tb/adc_output_formatter_bench.sv
// Self-checking bench for the converter output formatter
`timescale 1ns/1ps
`default_nettype none
module adc_output_formatter_bench;
  logic clk = 1'h0, rst_b = 1'h0, raw_over_range = 1'h0, twos_complement_en = 1'h0;
  logic randomizer_en = 1'h0, alt_polarity_en = 1'h0, output_disable = 1'h0;
  logic termination_en = 1'h0, clock_invert = 1'h0;
  logic [11:0] raw_sample = 12'h000;
  logic [2:0] test_pattern_sel = 3'h0, lvds_current_sel = 3'h0;
  logic [1:0] output_mode = 2'h0, clock_phase_field = 2'h0, power_down_field = 2'h0;
  wire [11:0] sample_bits, sample_bits_oe, decoded;
  wire [2:0] lvds_current_code;
  wire over_range_flag, over_range_flag_oe, forwarded_clock_pos, forwarded_clock_neg;
  wire forwarded_clock_oe, lvds_current_boost, lvds_termination_on;
  wire core_power_down, reference_power_down, samples_settling;
  logic [11:0] corner [3] = '{12'h800, 12'hFFF, 12'h000};
  logic [12:0] a, b, e;
  int miscompares = 0, n_tests = 0, k;
  adc_output_formatter #(.NAP_WAKE_CYCLES(20), .SLEEP_WAKE_CYCLES(40)) DUT (
    .clk, .rst_b, .raw_sample, .raw_over_range, .twos_complement_en, .randomizer_en,
    .alt_polarity_en, .test_pattern_sel, .output_mode, .output_disable, .termination_en,
    .lvds_current_sel, .clock_phase_field, .clock_invert, .power_down_field, .sample_bits,
    .sample_bits_oe, .over_range_flag, .over_range_flag_oe, .forwarded_clock_pos,
    .forwarded_clock_neg, .forwarded_clock_oe, .lvds_current_code, .lvds_current_boost,
    .lvds_termination_on, .core_power_down, .reference_power_down, .samples_settling);
  sample_receiver rx (.forwarded_clock_pos, .sample_bits, .randomizer_en, .alt_polarity_en,
    .decoded);
  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic [11:0] fmt(input logic [11:0] r, input logic t, x, p);
    logic [11:0] d;
    d = r;
    if (t && !p) d[11] = ~d[11];
    if (x) d[11:1] = d[11:1] ^ {11{d[0]}};
    return p ? d ^ 12'hAAA : d;
  endfunction
  function automatic logic [12:0] lanes(input logic [11:0] r, input int o);
    lanes = 13'h0000;
    for (int i = 0; i < 6; i++) lanes[i] = r[2 * i + o];
  endfunction
  initial begin
    forever #4 clk = ~clk;
  end
  initial begin
    #100000;
    miscompares++;
    end_of_test;
  end
  initial begin
    void'($urandom(32'h0856B599));
    repeat (20) @(posedge clk);
    rst_b <= 1'h1;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      raw_sample <= i < 3 ? corner[i] : 12'($urandom);
      raw_over_range <= 1'($urandom);
      twos_complement_en <= i < 3 || 1'($urandom);
      randomizer_en <= i > 2 && 1'($urandom);
      alt_polarity_en <= i > 2 && 1'($urandom);
      cyc(20);
      e = {raw_over_range, fmt(raw_sample, twos_complement_en, randomizer_en, alt_polarity_en)};
      check({over_range_flag, sample_bits}, e);
      e[11:0] = fmt(raw_sample, twos_complement_en && !alt_polarity_en, 1'h0, 1'h0);
      check({1'h0, decoded}, {1'h0, e[11:0]});
    end
    for (int p = 1; p < 5; p++) begin
      @(posedge clk);
      test_pattern_sel <= 3'(p);
      twos_complement_en <= 1'h1;
      randomizer_en <= 1'h1;
      alt_polarity_en <= p[0];
      cyc(20);
      a = {over_range_flag, sample_bits};
      cyc(8);
      b = {over_range_flag, sample_bits};
      e = p[0] ? 13'h1FFF : p == 4 ? 13'h1555 : 13'h0000;
      check(p < 3 ? a : a === e ? b : a, p < 3 ? e : ~e);
      check(a ^ b, p < 3 ? 13'h0000 : 13'h1FFF);
    end
    for (int s = 0; s < 8; s++) begin
      @(posedge clk);
      clock_phase_field <= s[1:0]; // Stabilizer taken as on
      clock_invert <= s[2];
      cyc(20);
      a[11:0] = sample_bits;
      for (k = 0; k < 9 && sample_bits === a[11:0]; k++) cyc(1);
      for (k = 0; k < 8 && forwarded_clock_pos !== clock_invert; k++) cyc(1);
      check(13'(k), 13'(s % 4));
    end
    @(posedge clk);
    output_mode <= 2'h1;
    test_pattern_sel <= 3'h0;
    clock_phase_field <= 2'h0;
    clock_invert <= 1'h0;
    randomizer_en <= 1'h0;
    alt_polarity_en <= 1'h0;
    termination_en <= 1'h1;
    lvds_current_sel <= 3'($urandom);
    cyc(20);
    check(13'({lvds_current_boost, lvds_termination_on, lvds_current_code}),
      13'({2'h3, lvds_current_sel}));
    e[11:0] = fmt(raw_sample, 1'h1, 1'h0, 1'h0);
    @(posedge forwarded_clock_pos);
    #1;
    check({forwarded_clock_neg, sample_bits}, lanes(e[11:0], 1));
    @(negedge forwarded_clock_pos);
    #1;
    check({~forwarded_clock_neg, sample_bits}, lanes(e[11:0], 0));
    @(posedge clk);
    output_disable <= 1'h1;
    cyc(3);
    check({sample_bits_oe, over_range_flag_oe | forwarded_clock_oe}, 13'h0000);
    @(posedge clk);
    output_disable <= 1'h0;
    cyc(3);
    check({sample_bits_oe, over_range_flag_oe & forwarded_clock_oe}, 13'h007F);
    for (int j = 1; j < 4; j += 2) begin
      @(posedge clk);
      power_down_field <= 2'(j);
      cyc(3);
      check(13'({core_power_down, reference_power_down, samples_settling}), 13'(j + 4));
      @(posedge clk);
      power_down_field <= 2'h0;
      cyc(10 * j);
      check(13'(samples_settling), 13'h0001);
      cyc(30);
      check(13'({core_power_down, samples_settling}), 13'h0000);
    end
    end_of_test;
  end
endmodule // adc_output_formatter_bench
bind adc_output_formatter adc_output_formatter_checker chk (
  .clk, .rst_b, .raw_over_range, .test_pattern_sel, .output_mode, .output_disable,
  .termination_en, .lvds_current_sel, .power_down_field, .sample_bits, .sample_bits_oe,
  .over_range_flag, .over_range_flag_oe, .forwarded_clock_oe, .forwarded_clock_pos,
  .clock_phase_field, .clock_invert, .lvds_current_code,
  .lvds_current_boost, .core_power_down, .reference_power_down, .samples_settling);
`default_nettype wire

// ### tb/adc_output_formatter_checker.sv
// Port assertions for the converter output formatter
`timescale 1ns/1ps
`default_nettype none
module adc_output_formatter_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic raw_over_range,
  input wire logic [2:0] test_pattern_sel,
  input wire logic [1:0] output_mode,
  input wire logic output_disable,
  input wire logic termination_en,
  input wire logic [2:0] lvds_current_sel,
  input wire logic [1:0] power_down_field,
  input wire logic [11:0] sample_bits,
  input wire logic [11:0] sample_bits_oe,
  input wire logic over_range_flag,
  input wire logic over_range_flag_oe,
  input wire logic forwarded_clock_oe,
  input wire logic forwarded_clock_pos,
  input wire logic [1:0] clock_phase_field,
  input wire logic clock_invert,
  input wire logic [2:0] lvds_current_code,
  input wire logic lvds_current_boost,
  input wire logic core_power_down,
  input wire logic reference_power_down,
  input wire logic samples_settling
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_ones;
    (test_pattern_sel == 3'h1 && output_mode == 2'h0 && power_down_field == 2'h0) [*8];
  endsequence
  sequence s_over;
    (raw_over_range && test_pattern_sel == 3'h0 && output_mode == 2'h0 && !power_down_field) [*8];
  endsequence
  sequence s_nap_exit;
    $past(power_down_field) == 2'h1 && power_down_field == 2'h0;
  endsequence
  property p_ones; s_ones |-> ##2 (sample_bits == 12'hFFF && over_range_flag); endproperty
  a_ones: assert property (p_ones) else $error("ones pattern wrong");
  property p_over; s_over |-> ##2 over_range_flag; endproperty
  a_over: assert property (p_over) else $error("overflow flag low");
  property p_wake; s_nap_exit |=> samples_settling [*8] ##[1:60] !samples_settling; endproperty
  a_wake: assert property (p_wake) else $error("wake count wrong");
  property p_edge;
    output_mode == 2'h0 && clock_phase_field == 2'h0 && !clock_invert && $changed(sample_bits)
      |-> $fell(forwarded_clock_pos);
  endproperty
  a_edge: assert property (p_edge) else $error("data not on falling clock");
  property p_off; output_disable |=> !sample_bits_oe && !over_range_flag_oe && !forwarded_clock_oe;
  endproperty
  a_off: assert property (p_off) else $error("outputs still driven");
  property p_boost;
    termination_en && output_mode == 2'h1 |=> lvds_current_boost
      && lvds_current_code == $past(lvds_current_sel);
  endproperty
  a_boost: assert property (p_boost) else $error("no current boost");
  property p_no_boost; !termination_en |=> !lvds_current_boost; endproperty
  a_no_boost: assert property (p_no_boost) else $error("stray boost");
  property p_sleep; power_down_field == 2'h3 |=> core_power_down && reference_power_down; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not applied");
  property p_nap; power_down_field == 2'h1 |=> core_power_down && !reference_power_down; endproperty
  a_nap: assert property (p_nap) else $error("nap not applied");
endmodule // adc_output_formatter_checker
`default_nettype wire

// ### tb/sample_receiver.sv
// Receiver model latching and decoding full-rate samples
`timescale 1ns/1ps
`default_nettype none
module sample_receiver (
  input wire logic forwarded_clock_pos,
  input wire logic [11:0] sample_bits,
  input wire logic randomizer_en,
  input wire logic alt_polarity_en,
  output logic [11:0] decoded
);
  logic [11:0] d;
  always @(posedge forwarded_clock_pos) begin
    d = sample_bits ^ (alt_polarity_en ? 12'hAAA : 12'h000);
    if (randomizer_en) d[11:1] = d[11:1] ^ {11{d[0]}};
    decoded <= d;
  end
endmodule // sample_receiver
`default_nettype wire
